// ==== shared/acdf_pkg.sv ====
// ----------------------------------------------------------------------------
// Purpose: Shared constants, types and helpers for the clock and decimation block
// Assumes: One 125 MHz system clock; all slower rates are enable pulses
// Notes: Register offsets are word indices on the documented register port
// ----------------------------------------------------------------------------
package acdf_pkg;

   // -------------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------------
   localparam logic [7:0] MODE_ADDR = 8'h01;      // Converter mode control
   localparam logic [7:0] SETUP0_ADDR = 8'h20;    // Setup configuration zero
   localparam logic [7:0] FILT0_ADDR = 8'h28;     // Filter configuration zero
   localparam logic [15:0] MODE_RST = 16'h0000;   // Mode reset value
   localparam logic [15:0] SETUP0_RST = 16'h1000; // Setup reset value
   localparam logic [15:0] FILT0_RST = 16'h0000;  // Filter reset value
   localparam logic [15:0] MODE_WMASK = 16'hef7c; // Reserved bits read zero
   localparam logic [15:0] SETUP0_WMASK = 16'h1fb0; // Reserved bits read zero
   localparam logic [15:0] FILT0_WMASK = 16'hffff;  // All bits used

   // -------------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------------
   localparam int REF_EN_BIT = 15;      // Internal reference enable
   localparam int SETTLED_ONLY_BIT = 13; // Settled-only output
   localparam int CLKSEL_LSB = 2;       // Clock source select, two bits
   localparam int DIRECT_BIT = 7;       // Sinc3 direct decimation
   localparam int ORDER_LSB = 5;        // Filter order, two bits
   localparam int ODR_LSB = 0;          // Output rate index, four bits used

   // Clock source select encodings; zero is the reset choice
   typedef enum logic [1:0] {
      ACDF_CLK_INT = 2'b00,     // Internal oscillator
      ACDF_CLK_INT_OUT = 2'b01, // Internal oscillator, also driven out
      ACDF_CLK_EXT = 2'b10,     // External clock on the clock pin
      ACDF_CLK_XTAL = 2'b11     // Crystal
   } acdf_clksel_t;

   localparam logic [1:0] ORDER_SINC3 = 2'b11; // Filter order code for sinc3

   // -------------------------------------------------------------------------
   // Rates
   // -------------------------------------------------------------------------
   localparam int OSC_HZ = 16_000_000; // Oscillator and crystal frequency
   localparam int MCLK_HZ = 2_000_000; // Nominal master clock
   localparam logic [2:0] OSC_DIV_LAST = 3'(OSC_HZ / MCLK_HZ - 1); // Divide by eight
   localparam logic [14:0] SINC5_DEC = 15'd32; // Modulator ticks per sinc5 output
   localparam logic [1:0] SINC3_SETTLE = 2'd3; // Outputs to settle, sinc3

   // -------------------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [14:0] cnt;  // Inputs taken so far
      logic [23:0] acc;  // Running sum
      logic [23:0] dout; // Last completed sum
      logic pulse;       // One cycle per completed sum
   } acdf_dec_st_t;

   typedef struct packed {
      logic [15:0] mode_q;   // Converter mode control
      logic [15:0] setup_q;  // Setup configuration zero
      logic [15:0] filt_q;   // Filter configuration zero
      logic [15:0] rdata_q;  // Read data
      logic osc_prev;        // Oscillator level last cycle
      logic xtal_prev;       // Crystal level last cycle
      logic ext_prev;        // External clock level last cycle
      logic [2:0] div_cnt;   // 16 MHz to 2 MHz divider
      logic mclk_tick;       // Master clock enable
      logic mod_phase;       // Master clock halving phase
      logic mod_tick;        // Modulator enable
      logic clk_out;         // Clock driven on the pin
      logic restart;         // Filter restart request
      logic [1:0] settle_cnt; // Outputs since restart, saturating
      logic [23:0] data_q;   // Result
      logic ready;           // Result strobe
      logic settled;         // Result is settled
   } acdf_st_t;

   // Second-stage decimation from the filter configuration
   function automatic logic [14:0] dec_n(input logic [15:0] f);
      logic [14:0] n;
      n = 15'd1562;
      if (f[DIRECT_BIT])
      begin
         n = (f[14:0] == 15'h0) ? 15'd1 : f[14:0];
      end
      else
      begin
         case (f[ODR_LSB +: 4])
            4'h0: n = 15'd1;
            4'h1: n = 15'd2;
            4'h2: n = 15'd3;
            4'h3: n = 15'd6;
            4'h4: n = 15'd12;
            4'h5: n = 15'd31;
            4'h6: n = 15'd62;
            4'h7: n = 15'd82;
            4'h8: n = 15'd156;
            4'h9: n = 15'd312;
            4'ha: n = 15'd525;
            4'hb: n = 15'd629;
            default: n = 15'd1562;
         endcase
      end
      return n;
   endfunction

endpackage

// ==== core/acdf_decim.sv ====
// ----------------------------------------------------------------------------
// Purpose: One decimation stage: sums a fixed number of inputs, then emits
// Assumes: tick is a one-cycle enable; limit is at least one
// Notes: clr drops a partial sum, used on restart of the filter
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
module acdf_decim (
   input wire logic ref_clk,        // System clock
   input wire logic resetn,         // Asynchronous reset, active low
   input wire logic clr,            // Drop partial sum
   input wire logic tick,           // Input strobe
   input wire logic [14:0] limit,   // Inputs per output
   input wire logic [23:0] din,     // Input sample
   output logic [23:0] dout,        // Completed sum
   output logic dvalid              // One cycle per completed sum
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   acdf_pkg::acdf_dec_st_t s_q; // Registered state
   acdf_pkg::acdf_dec_st_t s_d; // Next state

   // Sum and count update
   always_comb
   begin
      s_d = s_q;
      s_d.pulse = 1'b0;
      if (clr)
      begin
         // Restart discards partial work
         s_d.cnt = 15'h0;
         s_d.acc = 24'h0;
      end
      else if (tick)
      begin
         if (s_q.cnt + 15'h1 >= limit)
         begin
            // Last input of the group closes the sum
            s_d.dout = s_q.acc + din;
            s_d.pulse = 1'b1;
            s_d.cnt = 15'h0;
            s_d.acc = 24'h0;
         end
         else
         begin
            s_d.cnt = s_q.cnt + 15'h1;
            s_d.acc = s_q.acc + din;
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.dout;
   assign dvalid = s_q.pulse;

endmodule

// ==== core/acdf_top.sv ====
// ----------------------------------------------------------------------------
// Purpose: Master clock selection and decimation control of a sigma-delta ADC
// Assumes: Clock source pins arrive as levels synchronous to ref_clk
// Notes: Only setup zero is held; result is a plain bitstream sum
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
module acdf_top (
   input wire logic ref_clk,                 // System clock, 125 MHz
   input wire logic resetn,                  // Asynchronous reset, active low
   input wire logic reg_we,                  // Register write strobe
   input wire logic [7:0] reg_addr,          // Register index
   input wire logic [15:0] reg_wdata,        // Register write data
   output logic [15:0] reg_rdata,            // Register read data, one cycle late
   input wire logic int_osc_clk,             // Internal 16 MHz oscillator level
   input wire logic crystal_in,              // Crystal 16 MHz level
   input wire logic crystal_out_clock_io_i,  // Clock pin, input side
   output logic crystal_out_clock_io_o,      // Clock pin, output side
   output logic crystal_out_clock_io_oe,     // Clock pin drive enable
   input wire logic mod_bit,                 // Modulator bitstream
   output logic modulator_tick,              // Modulator rate enable
   output logic internal_ref_en,             // Internal reference enable
   output logic [23:0] result_data,          // Filter result
   output logic result_ready,                // Result strobe
   output logic result_settled               // Result is fully settled
);

   // -------------------------------------------------------------------------
   // State and decode
   // -------------------------------------------------------------------------
   acdf_pkg::acdf_st_t s; // Registered state
   acdf_pkg::acdf_st_t n; // Next state
   acdf_pkg::acdf_clksel_t clk_sel; // Current source choice
   logic cfg_wr; // Write that changes filter behaviour
   logic clr; // Restart both decimators
   logic is_sinc3; // Sinc3 path selected
   logic settled_only; // Emit settled results only
   logic [14:0] stage2_n; // Second-stage decimation
   logic [1:0] settle_n; // Outputs needed to settle
   logic [23:0] s1_out; // Sinc5 stage sum
   logic s1_valid; // Sinc5 stage output strobe
   logic [23:0] s2_out; // Final stage sum
   logic s2_valid; // Final stage output strobe
   logic [1:0] settle_nx; // Settle count after this output
   logic src_edge; // Selected oscillator or crystal rising edge; zero when external is selected

   assign clk_sel = acdf_pkg::acdf_clksel_t'(s.mode_q[acdf_pkg::CLKSEL_LSB +: 2]);
   assign cfg_wr = reg_we && (reg_addr == acdf_pkg::MODE_ADDR ||
                              reg_addr == acdf_pkg::FILT0_ADDR);
   assign clr = cfg_wr || s.restart;
   // Direct mapping forces sinc3 and ignores the order field
   assign is_sinc3 = s.filt_q[acdf_pkg::DIRECT_BIT] ||
                     s.filt_q[acdf_pkg::ORDER_LSB +: 2] == acdf_pkg::ORDER_SINC3;
   assign settled_only = s.mode_q[acdf_pkg::SETTLED_ONLY_BIT];
   assign stage2_n = acdf_pkg::dec_n(s.filt_q);

   // -------------------------------------------------------------------------
   // Settling depth
   // -------------------------------------------------------------------------
   // Sinc5+sinc1 at twelve or more sinc5 words is 2.6 kSPS or lower
   always_comb
   begin
      if (is_sinc3)
      begin
         settle_n = acdf_pkg::SINC3_SETTLE;
      end
      else if (stage2_n >= 15'd12)
      begin
         settle_n = 2'd1;
      end
      else if (stage2_n >= 15'd3)
      begin
         settle_n = 2'd2;
      end
      else
      begin
         settle_n = 2'd3;
      end
   end

   // -------------------------------------------------------------------------
   // Decimation stages
   // -------------------------------------------------------------------------
   // First stage: 32 modulator bits give the fixed 31.25 kSPS rate
   acdf_decim u_stage1 (
      .ref_clk (ref_clk),
      .resetn (resetn),
      .clr (clr),
      .tick (s.mod_tick),
      .limit (acdf_pkg::SINC5_DEC),
      .din ({23'h0, mod_bit}),
      .dout (s1_out),
      .dvalid (s1_valid)
   );

   // Second stage: sinc1 averaging or sinc3 decimation factor
   acdf_decim u_stage2 (
      .ref_clk (ref_clk),
      .resetn (resetn),
      .clr (clr),
      .tick (s1_valid),
      .limit (stage2_n),
      .din (s1_out),
      .dout (s2_out),
      .dvalid (s2_valid)
   );

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------
   always_comb
   begin
      n = s;
      n.ready = 1'b0;
      n.mclk_tick = 1'b0;
      n.mod_tick = 1'b0;
      n.restart = 1'b0;
      settle_nx = (s.settle_cnt == 2'd3) ? 2'd3 : s.settle_cnt + 2'd1;
      n.osc_prev = int_osc_clk;
      n.xtal_prev = crystal_in;
      n.ext_prev = crystal_out_clock_io_i;
      src_edge = 1'b0;

      // Register writes, reserved bits held at zero
      if (reg_we)
      begin
         unique case (reg_addr)
            acdf_pkg::MODE_ADDR: n.mode_q = reg_wdata & acdf_pkg::MODE_WMASK;
            acdf_pkg::SETUP0_ADDR: n.setup_q = reg_wdata & acdf_pkg::SETUP0_WMASK;
            acdf_pkg::FILT0_ADDR: n.filt_q = reg_wdata & acdf_pkg::FILT0_WMASK;
            default: n.rdata_q = s.rdata_q; // Unmapped write ignored
         endcase
      end

      // Read data, unmapped reads as zero
      unique case (reg_addr)
         acdf_pkg::MODE_ADDR: n.rdata_q = s.mode_q;
         acdf_pkg::SETUP0_ADDR: n.rdata_q = s.setup_q;
         acdf_pkg::FILT0_ADDR: n.rdata_q = s.filt_q;
         default: n.rdata_q = 16'h0;
      endcase

      // Master clock: 16 MHz sources divide by eight, external passes
      unique case (clk_sel)
         acdf_pkg::ACDF_CLK_INT, acdf_pkg::ACDF_CLK_INT_OUT:
            src_edge = int_osc_clk && !s.osc_prev;
         acdf_pkg::ACDF_CLK_XTAL:
            src_edge = crystal_in && !s.xtal_prev;
         acdf_pkg::ACDF_CLK_EXT:
            src_edge = 1'b0;
      endcase
      if (clk_sel == acdf_pkg::ACDF_CLK_EXT)
      begin
         // External clock is already the master clock
         n.mclk_tick = crystal_out_clock_io_i && !s.ext_prev;
         n.div_cnt = 3'h0;
      end
      else if (src_edge)
      begin
         n.div_cnt = (s.div_cnt == acdf_pkg::OSC_DIV_LAST) ? 3'h0 : s.div_cnt + 3'h1;
         n.mclk_tick = (s.div_cnt == acdf_pkg::OSC_DIV_LAST);
      end

      // Modulator runs at half the master clock; all rates follow it
      if (s.mclk_tick)
      begin
         n.mod_phase = !s.mod_phase;
         n.mod_tick = s.mod_phase;
      end

      // Oscillator copy for the clock pin, one cycle behind
      n.clk_out = int_osc_clk;

      // Result handling and settling count
      if (cfg_wr || s.restart)
      begin
         // A new configuration starts settling over
         n.settle_cnt = 2'h0;
      end
      else if (s2_valid)
      begin
         n.settle_cnt = settle_nx;
         if (settled_only)
         begin
            // Only settled results leave; filter restarts after each
            if (settle_nx >= settle_n)
            begin
               n.ready = 1'b1;
               n.settled = 1'b1;
               n.data_q = s2_out;
               n.restart = 1'b1;
            end
         end
         else
         begin
            n.ready = 1'b1;
            n.settled = (settle_nx >= settle_n);
            n.data_q = s2_out;
         end
      end
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   // Reset gives the internal oscillator and the reference off
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s <= '0;
         s.mode_q <= acdf_pkg::MODE_RST;
         s.setup_q <= acdf_pkg::SETUP0_RST;
         s.filt_q <= acdf_pkg::FILT0_RST;
      end
      else
      begin
         s <= n;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign reg_rdata = s.rdata_q;
   assign crystal_out_clock_io_o = s.clk_out;
   // Driving the pin disturbs dc performance, so only on request
   assign crystal_out_clock_io_oe = (clk_sel == acdf_pkg::ACDF_CLK_INT_OUT);
   assign modulator_tick = s.mod_tick;
   assign internal_ref_en = s.mode_q[acdf_pkg::REF_EN_BIT];
   assign result_data = s.data_q;
   assign result_ready = s.ready;
   assign result_settled = s.settled;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   a_clksel_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      $changed(s.mode_q[3:2]) |-> $past(reg_we) && $past(reg_addr) == acdf_pkg::MODE_ADDR)
      else $error("Clock select changed without a mode write");

   a_div_eight: assert property (@(posedge ref_clk) disable iff (!resetn)
      s.mclk_tick && $past(clk_sel) == acdf_pkg::ACDF_CLK_INT
      |-> $past(s.div_cnt) == 3'h7 && $past(int_osc_clk) && !$past(s.osc_prev))
      else $error("Master tick not on eighth oscillator edge");

   a_xtal_div: assert property (@(posedge ref_clk) disable iff (!resetn)
      s.mclk_tick && $past(clk_sel) == acdf_pkg::ACDF_CLK_XTAL
      |-> $past(s.div_cnt) == 3'h7 && $past(crystal_in))
      else $error("Crystal master tick not on eighth edge");

   a_ext_route: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_sel == acdf_pkg::ACDF_CLK_EXT && crystal_out_clock_io_i && !s.ext_prev
      && !cfg_wr |=> s.mclk_tick)
      else $error("External clock edge not routed");

   a_mod_half: assert property (@(posedge ref_clk) disable iff (!resetn)
      s.mod_tick |-> $past(s.mclk_tick) && $past(s.mod_phase))
      else $error("Modulator tick not at half master rate");

   a_clk_out: assert property (@(posedge ref_clk) disable iff (!resetn)
      crystal_out_clock_io_oe |-> crystal_out_clock_io_o == $past(int_osc_clk))
      else $error("Clock pin does not follow oscillator");

   a_direct_map: assert property (@(posedge ref_clk) disable iff (!resetn)
      s.filt_q[7] && s.filt_q[14:0] != 15'h0 |-> stage2_n == s.filt_q[14:0] && is_sinc3)
      else $error("Direct decimation not applied");

   a_sinc3_settle: assert property (@(posedge ref_clk) disable iff (!resetn)
      result_ready && result_settled && is_sinc3 && !settled_only |-> s.settle_cnt == 2'd3)
      else $error("Sinc3 result flagged settled too early");

   a_single_only: assert property (@(posedge ref_clk) disable iff (!resetn)
      result_ready && $past(settled_only) |-> result_settled ##1 s.settle_cnt == 2'd0)
      else $error("Unsettled result in settled-only mode");

   a_ref_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(internal_ref_en) |-> $past(reg_we) && $past(reg_wdata[15]))
      else $error("Reference enabled without a write");

endmodule

// ==== verif/acdf_src_model.sv ====
// Purpose: Far-side clock sources and modulator bitstream for the bench
// Assumes: Sources are levels synchronous to ref_clk
// Notes: Pin level merges device drive and external clock
`timescale 1ns/1ps
module acdf_src_model (
   input wire logic ref_clk, // System clock
   input wire logic resetn, // Reset, active low
   input wire logic [4:0] ext_half, // External clock half period in cycles
   input wire logic pin_o, // Device drive on the clock pin
   input wire logic pin_oe, // Device drive enable
   output logic int_osc_clk, // Oscillator level
   output logic crystal_in, // Crystal level
   output logic pin_lvl, // Resolved clock pin level
   output logic mod_bit // Bitstream, all ones so sums are known
);
   logic [1:0] osc_cnt; // Oscillator half period counter
   logic [4:0] ext_cnt; // External half period counter
   logic ext_lvl; // External clock level
   // ----------------------------------------
   // Sources: 16 MHz nearest to a whole count of cycles
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         osc_cnt <= 2'h0;
         ext_cnt <= 5'h00;
         int_osc_clk <= 1'b0;
         crystal_in <= 1'b0;
         ext_lvl <= 1'b0;
      end
      else
      begin
         osc_cnt <= osc_cnt + 2'h1;
         if (osc_cnt == 2'h3)
         begin
            int_osc_clk <= ~int_osc_clk;
            crystal_in <= ~crystal_in;
         end
         ext_cnt <= (ext_cnt + 5'h01 >= ext_half) ? 5'h00 : ext_cnt + 5'h01;
         if (ext_cnt + 5'h01 >= ext_half)
         begin
            ext_lvl <= ~ext_lvl;
         end
      end
   end
   // Device drive wins over the external source
   assign pin_lvl = pin_oe ? pin_o : ext_lvl;
   assign mod_bit = 1'b1;
endmodule

// ==== verif/tb_top.sv ====
// Purpose: Register, clock selection and filter tests of the block
// Assumes: 8 ns clock; sources from the source model
// Notes: Expected sums are 32 times N since the bitstream is all ones
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 1'b0, resetn = 1'b0, reg_we = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic int_osc_clk, crystal_in, pin, o, oe, mod_bit, mtick, ref_en, rdy, settled, p;
   logic [23:0] rdata24, v, res_data;
   logic [4:0] ext_half = 5'h08;
   int err_total = 0, compares = 0, cyc = 0;
   always #4 ref_clk = ~ref_clk;
   assign rdata24 = 24'(reg_rdata);
   acdf_src_model src (.ref_clk(ref_clk), .resetn(resetn), .ext_half(ext_half), .pin_o(o),
      .pin_oe(oe), .int_osc_clk(int_osc_clk), .crystal_in(crystal_in), .pin_lvl(pin),
      .mod_bit(mod_bit));
   acdf_top dut (.ref_clk(ref_clk), .resetn(resetn), .reg_we(reg_we), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_osc_clk(int_osc_clk),
      .crystal_in(crystal_in), .crystal_out_clock_io_i(pin), .crystal_out_clock_io_o(o),
      .crystal_out_clock_io_oe(oe), .mod_bit(mod_bit), .modulator_tick(mtick),
      .internal_ref_en(ref_en), .result_data(res_data), .result_ready(rdy),
      .result_settled(settled));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string nm, input logic [23:0] s, input logic [23:0] e);
      compares++;
      if (s !== e)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_we <= 1'b0;
   endtask
   // Read data is registered: address set, one edge, then sample
   task automatic rd(input logic [7:0] a, input logic [23:0] e, input string nm);
      @(posedge ref_clk);
      reg_addr <= a;
      @(posedge ref_clk);
      #1 check(nm, rdata24, e);
   endtask
   // Cycles to the next strobe, bounded so a dead source cannot hang
   task automatic wait_for(input bit res, output logic [23:0] n);
      n = 24'h0;
      do
         @(posedge ref_clk) #1 n++;
      while (((res ? rdy : mtick) !== 1'b1) && n < 24'd40000);
      // A strobe that never came is a mismatch, not a silent pass
      check("strobe wait", 24'(n >= 24'd40000), 24'h0);
   endtask
   task automatic gap(input logic [15:0] m, input logic [23:0] e);
      wr(8'h01, m);
      wait_for(1'b0, v);
      wait_for(1'b0, v);
      check("tick gap", v, e);
   endtask
   // Three results after a filter write; st gives settled per result
   task automatic runs(input logic [15:0] f, input logic [23:0] d, input logic [2:0] st);
      wr(8'h28, f);
      for (int k = 0; k < 3; k++)
      begin
         wait_for(1'b1, v);
         check("data", res_data, d);
         check("settled", 24'(settled), 24'(st[k]));
      end
   endtask
   // Hang guard, well above the longest direct mode result
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         err_total++;
         tally_and_finish();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      // Register port stays idle while the crystal oscillation builds up
      repeat (16) @(posedge ref_clk);
      rd(8'h01, 24'h0000, "mode reset");
      rd(8'h20, 24'h1000, "setup reset");
      rd(8'h28, 24'h0000, "filter reset");
      rd(8'h55, 24'h0000, "unmapped");
      wr(8'h20, 16'hffff);
      rd(8'h20, 24'h1fb0, "setup mask");
      check("ref off", 24'(ref_en), 24'h0);
      check("pin idle", 24'(oe), 24'h0);
      wr(8'h01, 16'hffff);
      rd(8'h01, 24'hef7c, "mode mask");
      check("ref on", 24'(ref_en), 24'h1);
      gap(16'h0000, 24'd128);
      gap(16'h000c, 24'd128);
      gap(16'h0008, 24'd32);
      ext_half <= 5'h10;
      gap(16'h0008, 24'd64);
      wr(8'h01, 16'h0004);
      #1 check("pin drive", 24'(oe), 24'h1);
      repeat (8)
      begin
         @(posedge ref_clk) #1 p = int_osc_clk;
         @(posedge ref_clk) #1 check("pin out", 24'(o), 24'(p));
      end
      ext_half <= 5'h02;
      wr(8'h01, 16'h0008);
      runs(16'h0000, 24'd32, 3'b100);
      runs(16'h0060, 24'd32, 3'b100);
      runs(16'h0004, 24'd384, 3'b111);
      wr(8'h01, 16'h2008);
      wr(8'h28, 16'h0060);
      wait_for(1'b1, v);
      check("single gap", 24'(v > 24'd700), 24'h1);
      check("single settled", 24'(settled), 24'h1);
      wr(8'h01, 16'h0008);
      wr(8'h28, 16'h0080);
      wait_for(1'b1, v);
      check("direct sum", res_data, 24'd4096);
      tally_and_finish();
   end
endmodule
